// ===== tb/cpu_core_model.sv
// Processor core model issuing clear and power-save instructions
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic clk_sys_i,
  output logic clear_o,
  output logic psave_o,
  output logic sleep_o
);
  initial begin
    clear_o = 1'b0;
    psave_o = 1'b0;
    sleep_o = 1'b0;
  end

  // One clear per call, from the main loop, well before time-out
  task automatic issue_clear();
    @(posedge clk_sys_i);
    clear_o <= 1'b1;
    @(posedge clk_sys_i);
    clear_o <= 1'b0;
  endtask : issue_clear

  task automatic issue_psave(input logic sleep);
    @(posedge clk_sys_i);
    psave_o <= 1'b1;
    sleep_o <= sleep;
    @(posedge clk_sys_i);
    psave_o <= 1'b0;
  endtask : issue_psave
endmodule : cpu_core_model
`default_nettype wire

// ===== tb/windowed_watchdog_timer_tb.sv
// Self-checking testbench of the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
  localparam int TK = 9;
  localparam logic [3:0] ST = watchdog_pkg::RESET_CONTROL_STATUS_OFS;
  logic clk_sys_i, rst_i, por, lp_clk, sw_done, wr, rd;
  logic clr, psave, psleep, dev_rst, wake, en;
  logic [15:0] cfg, wdata, rdata;
  logic [3:0] addr;
  int fails, checks_done;

  windowed_watchdog_timer i_windowed_watchdog_timer (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_on_reset_i(por),
    .config_word_i(cfg), .low_power_rc_clock_i(lp_clk),
    .watchdog_clear_instr_i(clr), .power_save_instr_i(psave),
    .power_save_sleep_i(psleep), .other_wake_i(1'b0),
    .clock_switch_done_i(sw_done), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .device_reset_o(dev_rst),
    .wake_o(wake), .watchdog_enabled_o(en)
  );
  cpu_core_model i_cpu_core_model (
    .clk_sys_i(clk_sys_i), .clear_o(clr), .psave_o(psave),
    .sleep_o(psleep)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Slow clock of 9 system cycles, phase unrelated
  initial begin
    lp_clk = 1'b0;
    #3;
    forever #36 lp_clk = ~lp_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] near(input int n, input int t);
    return {15'h0, (n >= t * TK - 10) && (n <= t * TK + 10)};
  endfunction : near

  task automatic do_reset(input logic [15:0] c, input logic p);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    por <= p;
    cfg <= c;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask : do_reset

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask : rd_chk

  // Cycles until reset (w=0) or wake (w=1) pulse, lim if none
  task automatic wait_ev(input logic w, input int lim, output int n);
    n = 0;
    while (n < lim) begin
      @(posedge clk_sys_i);
      #1;
      if ((w ? wake : dev_rst) === 1'b1) break;
      n++;
    end
  endtask : wait_ev

  task automatic t_regs();
    do_reset(16'hFFE0, 1'b1);
    check({15'h0, en}, 16'h0001);
    rd_chk(watchdog_pkg::CONFIG_WORD_ONE_OFS, 16'h03C0);
    rd_chk(ST, 16'h0000);
    wr_reg(ST, 16'hFFFF);
    rd_chk(ST, 16'h003C);
    rd_chk(4'h8, 16'h0000);
    wr_reg(ST, 16'h0000);
  endtask : t_regs

  task automatic t_period(input logic [15:0] c, input int t);
    int n;
    do_reset(c, 1'b1);
    wait_ev(1'b0, t * TK + 40, n);
    check(near(n, t), 16'h0001);
    rd_chk(ST, 16'h0010);
  endtask : t_period

  task automatic t_clear();
    int n;
    do_reset(16'h03C0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wait_ev(1'b0, 20 * TK, n);
      check(16'(n), 16'(20 * TK));
      if (i % 2 == 0) begin
        i_cpu_core_model.issue_clear();
      end else begin
        @(posedge clk_sys_i);
        sw_done <= 1'b1;
        @(posedge clk_sys_i);
        sw_done <= 1'b0;
      end
    end
  endtask : t_clear

  task automatic t_sleep(input logic s, input logic [15:0] e);
    int n;
    do_reset(16'h03C0, 1'b1);
    wait_ev(1'b0, 16 * TK, n);
    i_cpu_core_model.issue_psave(s);
    wait_ev(1'b1, 32 * TK + 40, n);
    check(near(n, 32), 16'h0001);
    rd_chk(ST, e);
  endtask : t_sleep

  task automatic t_soft();
    int n;
    do_reset(16'h0340, 1'b1);
    check({15'h0, en}, 16'h0000);
    wait_ev(1'b0, 64 * TK, n);
    check(16'(n), 16'(64 * TK));
    wr_reg(ST, 16'h0020);
    #1;
    check({15'h0, en}, 16'h0001);
    wait_ev(1'b0, 32 * TK + 40, n);
    check(near(n, 32), 16'h0001);
    rd_chk(ST, 16'h0030);
    do_reset(16'h0340, 1'b0);
    rd_chk(ST, 16'h0010);
    do_reset(16'h0340, 1'b1);
    rd_chk(ST, 16'h0000);
  endtask : t_soft

  task automatic t_window();
    int n;
    do_reset(16'h0380, 1'b1);
    wait_ev(1'b0, 5 * TK, n);
    i_cpu_core_model.issue_clear();
    #1;
    check({15'h0, dev_rst}, 16'h0001);
    do_reset(16'h0080, 1'b1);
    wait_ev(1'b0, 12 * TK, n);
    i_cpu_core_model.issue_clear();
    wait_ev(1'b0, 32 * TK + 40, n);
    check(near(n, 32), 16'h0001);
  endtask : t_window

  initial begin
    fails = 0;
    checks_done = 0;
    rst_i = 1'b1;
    por = 1'b1;
    cfg = 16'hFFE0;
    sw_done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs();
    t_period(16'h03C0, 32);
    t_period(16'h03D0, 128);
    t_period(16'h03C1, 64);
    t_period(16'h03C3, 256);
    t_clear();
    t_sleep(1'b1, 16'h0018);
    t_sleep(1'b0, 16'h0014);
    t_soft();
    t_window();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    wrap_up();
  end
endmodule : windowed_watchdog_timer_tb
`default_nettype wire

// ===== verilog/watchdog_pkg.sv
// Shared constants and types of the windowed watchdog timer
package watchdog_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] RESET_CONTROL_STATUS_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CONFIG_WORD_ONE_OFS = 4'h4;

  // Reset control and status bit positions
  localparam int SOFT_EN_BIT = 5;
  localparam int TIMEOUT_FLAG_BIT = 4;
  localparam int SLEEP_FLAG_BIT = 3;
  localparam int IDLE_FLAG_BIT = 2;

  // ----------------------------------------------------------------
  // Counter chain and timing
  // ----------------------------------------------------------------
  localparam int SLOW_CLK_FREQ_KHZ = 31;
  localparam int BASE_SHORT_MS = 1;
  localparam int BASE_LONG_MS = 4;
  localparam int PRE_SHORT_BITS = 5;
  localparam int PRE_LONG_BITS = 7;
  localparam int POST_BITS = 4;
  localparam int POST_MAX_SHIFT = 15;
  localparam int COUNT_W = PRE_LONG_BITS + POST_MAX_SHIFT;
  localparam int TAP_W = 5;

  // Allowed-window start, in eighths of the period
  localparam logic [3:0] WIN_START_25 = 4'h6;
  localparam logic [3:0] WIN_START_375 = 4'h5;
  localparam logic [3:0] WIN_START_50 = 4'h4;
  localparam logic [3:0] WIN_START_75 = 4'h2;
  localparam int EIGHTH_SHIFT = 3;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [1:0] window_size_select;
    logic fuse_watchdog_enable;
    logic window_disable_cfg;
    logic rsvd_5;
    logic prescale_select_cfg;
    logic [3:0] postscale_select_cfg;
  } config_word_s;

  localparam logic [15:0] CONFIG_USED_MASK = 16'h03DF;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SLEEP = 3'h2,
    ST_IDLE = 3'h4
  } power_state_e;

endpackage : watchdog_pkg

// ===== verilog/windowed_watchdog_timer.sv
// Windowed watchdog timer with prescaler, postscaler and status register
// Function
// - Low-power clock, prescale 32 or 128
// - Base period about 1 or 4 ms
// - Four-bit postscale code, fixed configuration
// - Period doubles per code, up to 131 s
// - Reset and power save clear the chain
// - Software enable clears the chain
// - Completed clock switch clears the chain
// - Clear instruction, window-gated in windowed mode
// - Keeps counting asleep; time-out wakes device
// - Software enable bit turns watchdog on
// - Unimplemented status bits read zero
// - Status reset value depends on reset type
// - Time-out while running resets device
// - Time-out sets flag, plus sleep/idle flag
// - Fuse enable forces watchdog always on
// - Early clear in windowed mode resets
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer #(
  parameter int COUNT_W = watchdog_pkg::COUNT_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic power_on_reset_i,
  input wire logic [15:0] config_word_i,
  input wire logic low_power_rc_clock_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_sleep_i,
  input wire logic other_wake_i,
  input wire logic clock_switch_done_i,
  input wire logic [watchdog_pkg::ADDR_W-1:0] addr_i,
  input wire logic [watchdog_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [watchdog_pkg::DATA_W-1:0] rd_data_o,
  output logic device_reset_o,
  output logic wake_o,
  output logic watchdog_enabled_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (COUNT_W != watchdog_pkg::COUNT_W) begin : g_bad_width
    $error("COUNT_W must equal the full prescale plus postscale chain");
  end

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  watchdog_pkg::config_word_s cfg_reg;

  // Fixed configuration is sampled while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_reg <= watchdog_pkg::config_word_s'(config_word_i &
                 watchdog_pkg::CONFIG_USED_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Low-power clock synchroniser
  // ----------------------------------------------------------------
  logic slow_meta_reg;
  logic slow_sync_reg;
  logic slow_prev_reg;
  logic slow_tick;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      slow_meta_reg <= low_power_rc_clock_i;
      slow_sync_reg <= slow_meta_reg;
      slow_prev_reg <= slow_sync_reg;
    end
  end

  // One tick per rising edge of the slow clock
  assign slow_tick = slow_sync_reg & ~slow_prev_reg;

  // ----------------------------------------------------------------
  // Status register and enable
  // ----------------------------------------------------------------
  logic soft_en_reg;
  logic timeout_flag_reg;
  logic sleep_flag_reg;
  logic idle_flag_reg;
  logic wr_status;
  logic soft_rise;
  logic enabled;
  logic window_mode;

  assign wr_status = wr_i &&
                     (addr_i == watchdog_pkg::RESET_CONTROL_STATUS_OFS);
  assign soft_rise = wr_status && wr_data_i[watchdog_pkg::SOFT_EN_BIT] &&
                     !soft_en_reg;
  assign enabled = cfg_reg.fuse_watchdog_enable | soft_en_reg;
  assign window_mode = cfg_reg.fuse_watchdog_enable &
                       ~cfg_reg.window_disable_cfg;
  assign watchdog_enabled_o = enabled;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      soft_en_reg <= 1'b0;
    end else if (wr_status) begin
      soft_en_reg <= wr_data_i[watchdog_pkg::SOFT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Counter chain
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0] count_reg;
  logic [watchdog_pkg::TAP_W-1:0] tap;
  logic [COUNT_W:0] period;
  logic [COUNT_W-1:0] last_count;
  logic [3:0] win_start;
  logic [COUNT_W+3:0] threshold_wide;
  logic early;
  logic running;
  logic chain_clear;
  logic clear_ok;
  logic early_clear;
  logic timeout;
  watchdog_pkg::power_state_e state_reg;

  assign running = (state_reg == watchdog_pkg::ST_RUN);

  // Prescale of 32 gives about 1 ms, 128 about 4 ms at 31 kHz
  assign tap = cfg_reg.prescale_select_cfg ?
               watchdog_pkg::TAP_W'(watchdog_pkg::PRE_LONG_BITS) :
               watchdog_pkg::TAP_W'(watchdog_pkg::PRE_SHORT_BITS);
  assign period = (COUNT_W+1)'(1) << (tap +
                  watchdog_pkg::TAP_W'(cfg_reg.postscale_select_cfg));
  assign last_count = COUNT_W'(period - (COUNT_W+1)'(1));

  always_comb begin
    if (cfg_reg.window_size_select == 2'h3) begin
      win_start = watchdog_pkg::WIN_START_25;
    end else if (cfg_reg.window_size_select == 2'h2) begin
      win_start = watchdog_pkg::WIN_START_375;
    end else if (cfg_reg.window_size_select == 2'h1) begin
      win_start = watchdog_pkg::WIN_START_50;
    end else begin
      win_start = watchdog_pkg::WIN_START_75;
    end
  end

  assign threshold_wide = (COUNT_W+4)'(period >> watchdog_pkg::EIGHTH_SHIFT) *
                          (COUNT_W+4)'(win_start);
  assign early = (COUNT_W+4)'(count_reg) < threshold_wide;

  assign clear_ok = watchdog_clear_instr_i && running && enabled &&
                    !(window_mode && early);
  assign early_clear = watchdog_clear_instr_i && running && enabled &&
                       window_mode && early;
  assign chain_clear = power_save_instr_i || soft_rise ||
                       clock_switch_done_i || clear_ok ||
                       early_clear;
  assign timeout = enabled && slow_tick && (count_reg == last_count) &&
                   !chain_clear;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || chain_clear || !enabled) begin
      count_reg <= '0;
    end else if (slow_tick) begin
      if (count_reg == last_count) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + COUNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-save state and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= watchdog_pkg::ST_RUN;
    end else begin
      case (state_reg)
        watchdog_pkg::ST_RUN: begin
          if (power_save_instr_i) begin
            state_reg <= power_save_sleep_i ? watchdog_pkg::ST_SLEEP :
                         watchdog_pkg::ST_IDLE;
          end
        end
        watchdog_pkg::ST_SLEEP, watchdog_pkg::ST_IDLE: begin
          if (timeout || other_wake_i) begin
            state_reg <= watchdog_pkg::ST_RUN;
          end
        end
        default: begin
          state_reg <= watchdog_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      device_reset_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      device_reset_o <= (timeout && running) || early_clear;
      wake_o <= timeout && !running;
    end
  end

  // ----------------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------------
  // Flags survive every reset except power-on; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      if (power_on_reset_i) begin
        timeout_flag_reg <= 1'b0;
        sleep_flag_reg <= 1'b0;
        idle_flag_reg <= 1'b0;
      end
    end else begin
      if (timeout || early_clear) begin
        timeout_flag_reg <= 1'b1;
      end else if (wr_status) begin
        timeout_flag_reg <= wr_data_i[watchdog_pkg::TIMEOUT_FLAG_BIT];
      end
      if (timeout && state_reg == watchdog_pkg::ST_SLEEP) begin
        sleep_flag_reg <= 1'b1;
      end else if (wr_status) begin
        sleep_flag_reg <= wr_data_i[watchdog_pkg::SLEEP_FLAG_BIT];
      end
      if (timeout && state_reg == watchdog_pkg::ST_IDLE) begin
        idle_flag_reg <= 1'b1;
      end else if (wr_status) begin
        idle_flag_reg <= wr_data_i[watchdog_pkg::IDLE_FLAG_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [watchdog_pkg::DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[watchdog_pkg::SOFT_EN_BIT] = soft_en_reg;
    status_word[watchdog_pkg::TIMEOUT_FLAG_BIT] = timeout_flag_reg;
    status_word[watchdog_pkg::SLEEP_FLAG_BIT] = sleep_flag_reg;
    status_word[watchdog_pkg::IDLE_FLAG_BIT] = idle_flag_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rd_i) begin
      rd_data_o <= '0;
    end else if (addr_i == watchdog_pkg::RESET_CONTROL_STATUS_OFS) begin
      rd_data_o <= status_word;
    end else if (addr_i == watchdog_pkg::CONFIG_WORD_ONE_OFS) begin
      rd_data_o <= cfg_reg;
    end else begin
      rd_data_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_run_expiry;
    running && timeout;
  endsequence

  sequence s_sleep_expiry;
    (state_reg == watchdog_pkg::ST_SLEEP) && timeout;
  endsequence

  sequence s_idle_expiry;
    (state_reg == watchdog_pkg::ST_IDLE) && timeout;
  endsequence

  AST_TIMEOUT_RESET: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    s_run_expiry |=> device_reset_o && !wake_o)
    else $error("Time-out while running gave no device reset");

  AST_SLEEP_WAKE: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    s_sleep_expiry |=> wake_o && sleep_flag_reg && timeout_flag_reg &&
    running && !device_reset_o)
    else $error("Time-out in sleep gave no wake with flags");

  AST_IDLE_WAKE: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    s_idle_expiry |=> wake_o && idle_flag_reg && timeout_flag_reg &&
    running && !device_reset_o)
    else $error("Time-out in idle gave no wake with flags");

  // A clear in the first quarter is early for every window size
  AST_EARLY_CLEAR: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (watchdog_clear_instr_i && running && enabled && window_mode &&
     count_reg < COUNT_W'(period >> 2)) |=> device_reset_o)
    else $error("Clear in closed window did not reset");

  AST_CLEAR_OK: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (watchdog_clear_instr_i && running && enabled && !window_mode)
    |=> count_reg == '0 && !device_reset_o)
    else $error("Clear in normal mode did not empty counter");

  AST_SOFT_ENABLE: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    soft_rise |=> soft_en_reg && enabled && count_reg == '0)
    else $error("Software enable did not start a clean count");

  AST_SWITCH_CLEAR: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    clock_switch_done_i |=> count_reg == '0 && !device_reset_o)
    else $error("Clock switch did not empty counter");

  AST_FLAG_SET_WINS: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (timeout && wr_status && !wr_data_i[watchdog_pkg::TIMEOUT_FLAG_BIT])
    |=> timeout_flag_reg)
    else $error("Time-out flag lost against a clear");

  AST_POWER_SAVE_CLEAR: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (power_save_instr_i && running) |=> count_reg == '0 && !running)
    else $error("Power save did not clear counter");

  AST_COUNT_STEP: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (enabled && slow_tick && !chain_clear && count_reg != last_count)
    |=> count_reg == $past(count_reg) + COUNT_W'(1))
    else $error("Counter missed a slow-clock tick");

  AST_FUSE_ON: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    cfg_reg.fuse_watchdog_enable |-> watchdog_enabled_o)
    else $error("Fuse enable did not force watchdog on");

  AST_UNIMPL_ZERO: assert property (@(posedge clk_sys_i)
    disable iff (rst_i)
    (rd_i && addr_i == watchdog_pkg::RESET_CONTROL_STATUS_OFS)
    |=> rd_data_o[13:10] == 4'h0)
    else $error("Unimplemented status bits read nonzero");

endmodule : windowed_watchdog_timer

`default_nettype wire
